// >>> dv/cdap_cam_model.sv
// Purpose: behavioural external cam
// Assumes: one data store and a fixed status word
// Notes: idle bus toggles so a stale value never passes
`timescale 1ns/1ns
module cdap_cam_model #(parameter logic [15:0] status_word = 16'h5a3c) (
    input wire logic aclk,
    input wire logic [15:0] cam_dq_out,
    input wire logic cam_enable_n,
    input wire logic cam_write_n,
    input wire logic cam_command_select_n,
    output logic [15:0] cam_dq_in
);
    logic [15:0] data_q = 16'h0000;
    logic [15:0] last_q = 16'h0000;
    // data writes land while enable is low
    always @(posedge aclk) begin
        if (!cam_enable_n && !cam_write_n && cam_command_select_n) data_q <= cam_dq_out;
        last_q <= cam_dq_in;
    end
    // data or status during a low-enable read, else the inverted last value
    assign cam_dq_in = (!cam_enable_n && cam_write_n) ?
        (cam_command_select_n ? data_q : status_word) : ~last_q;
endmodule

// >>> dv/cdap_checker.sv
// Purpose: port checks for cdap_top
// Assumes: host writes use full strobes
// Notes: bound to the top after the module
`timescale 1ns/1ns
module cdap_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic engine_enable_n,
    input wire logic engine_write_n,
    input wire logic [15:0] cam_dq_out,
    input wire logic cam_dq_oe_n,
    input wire logic cam_enable_n,
    input wire logic cam_write_n,
    input wire logic cam_command_select_n,
    input wire logic cam_match_flag_enable_n,
    input wire logic direct_access
);
    logic [3:0] aq;
    logic [15:0] wq;
    logic bq;
    logic settled;
    wire upd = s_axi_bvalid && !bq;
    wire pdw = upd && aq == cdap_pkg::addr_pin_drive;
    wire [3:0] stb = {cam_enable_n, cam_write_n, cam_command_select_n, cam_match_flag_enable_n};
    // remember the last accepted write, pins move when bvalid rises
    always_ff @(posedge aclk) begin
        if (s_axi_awvalid && s_axi_awready) aq <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready) wq <= s_axi_wdata[15:0];
        bq <= s_axi_bvalid;
        // pins still show reset values one edge after release
        settled <= aresetn;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn || !settled);
    property p_bit4; pdw |-> direct_access == wq[cdap_pkg::bit_access]; endproperty
    a_bit4: assert property (p_bit4) else $error("direct access flag wrong");
    property p_strobes; pdw && wq[4] |-> stb == wq[3:0]; endproperty
    a_strobes: assert property (p_strobes) else $error("strobes differ from register");
    property p_hold; direct_access ##1 (direct_access && !upd) |-> $stable(stb) && $stable(cam_dq_out);
    endproperty
    a_hold: assert property (p_hold) else $error("pins moved without a write");
    property p_engine;
        !direct_access ##1 (!direct_access && $stable(engine_enable_n) && $stable(engine_write_n))
        |-> cam_enable_n == engine_enable_n && cam_write_n == engine_write_n;
    endproperty
    a_engine: assert property (p_engine) else $error("engine drive not passed");
    property p_drive; direct_access && !cam_write_n |-> !cam_dq_oe_n; endproperty
    a_drive: assert property (p_drive) else $error("bus not driven on write");
    property p_release; direct_access && cam_write_n |-> cam_dq_oe_n; endproperty
    a_release: assert property (p_release) else $error("bus driven on read");
    property p_dq; upd && aq == cdap_pkg::addr_data_word && direct_access && !cam_write_n
        |-> cam_dq_out == wq; endproperty
    a_dq: assert property (p_dq) else $error("data bus differs from data word");
    property p_bresp;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
    endproperty
    a_bresp: assert property (p_bresp) else $error("write response late");
    c_enter: cover property ($rose(direct_access));
    c_low: cover property (direct_access && !cam_enable_n);
    c_leave: cover property ($fell(direct_access));
endmodule
bind cdap_top cdap_checker i_cdap_checker (.*);

// >>> dv/cdap_top_test.sv
// Purpose: register-level test of cdap_top
// Assumes: bready and rready held high
// Notes: runs each cam cycle type, then a configuration pass
`timescale 1ns/1ns
module cdap_top_test;
    localparam logic [15:0] status_word = 16'h5a3c;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1, engine_dq_oe_n = 1'b1;
    logic [15:0] engine_dq_out = 16'h00c3;
    logic engine_enable_n = 1'b0, engine_write_n = 1'b1;
    logic engine_command_select_n = 1'b0, engine_match_flag_enable_n = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [15:0] cam_dq_in, cam_dq_out;
    logic cam_dq_oe_n, cam_enable_n, cam_write_n, cam_command_select_n;
    logic cam_match_flag_enable_n, direct_access;
    int miscompares = 0;
    int comparisons = 0;
    logic [15:0] stored = 16'h0000;
    // cam register encodings belong to the cam itself; these are plain stand-ins
    localparam logic [15:0] fg_control = 16'h0001;
    localparam logic [15:0] bg_control = 16'h0002;
    localparam logic [15:0] fg_segments = 16'h0003;
    localparam logic [15:0] bg_segments = 16'h0004;
    localparam logic [15:0] fg_source_dest = 16'h0005;
    localparam logic [15:0] bg_source_dest = 16'h0006;
    cdap_top i_cdap_top (.*);
    cdap_cam_model #(.status_word(status_word)) i_cdap_cam_model (.*);
    // 25 mhz
    initial begin
        forever #20 aclk = ~aclk;
    end
    task print_verdict;
        if (miscompares == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk(input logic ok);
        comparisons++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("mismatch at %0t ns: unexpected value", $time);
        end
    endtask
    // both channels offered together, each dropped when taken
    task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        chk(n < 50 && s_axi_bresp === r);
        if (n == 50) print_verdict;
    endtask
    task rd(input logic [3:0] a, input logic [15:0] e, input logic [1:0] r);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        chk(n < 50 && s_axi_rdata === {16'h0000, e} && s_axi_rresp === r);
        if (n == 50) print_verdict;
    endtask
    // write bit high means the bus is released
    task pins(input logic [4:0] v, input logic [15:0] w);
        chk(direct_access === v[4] && cam_dq_oe_n === v[2] && (v[2] || cam_dq_out === w) &&
            {cam_enable_n, cam_write_n, cam_command_select_n, cam_match_flag_enable_n} === v[3:0]);
    endtask
    task eng(input logic [15:0] d);
        chk(direct_access === 1'b0 && cam_dq_out === d && cam_dq_oe_n === engine_dq_oe_n &&
            {cam_enable_n, cam_write_n, cam_command_select_n, cam_match_flag_enable_n} ===
            {engine_enable_n, engine_write_n, engine_command_select_n,
             engine_match_flag_enable_n});
    endtask
    // one cam cycle: load the word on write cycles, then setup, enable low, enable high
    task cyc(input logic [7:0] s, input logic [15:0] w);
        if (!s[2]) wr(cdap_pkg::addr_data_word, {16'h0000, w}, cdap_pkg::resp_okay);
        if (!s[2] && s[1]) stored = w;
        wr(cdap_pkg::addr_pin_drive, {24'h000000, s}, cdap_pkg::resp_okay);
        pins(s[4:0], w);
        wr(cdap_pkg::addr_pin_drive, {24'h000000, s & 8'hf7}, cdap_pkg::resp_okay);
        pins(s[4:0] & 5'h17, w);
        wr(cdap_pkg::addr_pin_drive, {24'h000000, s}, cdap_pkg::resp_okay);
        pins(s[4:0], w);
        // read cycles: command reads give status, data reads the last stored word
        if (s[2]) rd(cdap_pkg::addr_status, s[1] ? stored : status_word,
            cdap_pkg::resp_okay);
    endtask
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(cdap_pkg::addr_pin_drive, cdap_pkg::pin_drive_reset, cdap_pkg::resp_okay);
        rd(cdap_pkg::addr_data_word, 16'h0000, cdap_pkg::resp_okay);
        wr(cdap_pkg::addr_pin_drive, 32'h0f, cdap_pkg::resp_okay);
        eng(16'h00c3);
        cyc(8'h1d, 16'h0000);
        cyc(8'h19, 16'h1234);
        cyc(8'h1b, 16'hbeef);
        cyc(8'h1f, 16'h0000);
        for (int k = 0; k < 4; k++) cyc(8'h1b, k[15:0]);
        cyc(8'h1b, bg_control);
        cyc(8'h1b, 16'h7f00);
        for (int k = 1; k < 4; k++) cyc(8'h1b, 16'hffff);
        cyc(8'h1b, bg_segments);
        cyc(8'h1b, bg_source_dest);
        cyc(8'h1b, fg_control);
        cyc(8'h1b, fg_segments);
        cyc(8'h1b, 16'h8000);
        for (int k = 1; k < 4; k++) cyc(8'h1b, 16'h0000);
        cyc(8'h1b, fg_source_dest);
        cyc(8'h1f, 16'h0000);
        for (int i = 0; i < 4; i++) wr(cdap_pkg::addr_pin_drive, i < 2 ? 32'h1f : 32'h0f,
            cdap_pkg::resp_okay);
        eng(16'h00c3);
        engine_enable_n <= 1'b1;
        engine_write_n <= 1'b0;
        engine_command_select_n <= 1'b1;
        engine_match_flag_enable_n <= 1'b0;
        engine_dq_oe_n <= 1'b0;
        engine_dq_out <= 16'h3c00;
        repeat (2) @(posedge aclk);
        eng(16'h3c00);
        wr(4'hc, 32'h1f, cdap_pkg::resp_slverr);
        rd(4'hc, 16'h0000, cdap_pkg::resp_slverr);
        rd(cdap_pkg::addr_pin_drive, 16'h000f, cdap_pkg::resp_okay);
        print_verdict;
    end
endmodule

// >>> verilog/cdap_pkg.sv
// Purpose: constants for the cam direct access port register bank
// Assumes: axi4-lite 32-bit data, one aligned word per register
// Notes: offsets are byte addresses
package cdap_pkg;
    localparam logic [3:0] addr_pin_drive = 4'h0;
    localparam logic [3:0] addr_data_word = 4'h4;
    localparam logic [3:0] addr_status = 4'h8;
    localparam logic [15:0] pin_drive_reset = 16'h000f;
    localparam int bit_access = 4;
    localparam int bit_enable = 3;
    localparam int bit_write = 2;
    localparam int bit_cmd = 1;
    localparam int bit_match = 0;
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
    // idle strobe levels of the device's own engine
    localparam logic [3:0] strobes_idle = 4'hf;
endpackage

// >>> verilog/cdap_top.sv
// Purpose: host direct access to an external cam through a pin-drive register
// Assumes: one clock, synchronous active-low reset, axi4-lite slave
// Notes: the internal lookup engine is represented by engine_* inputs
//
// What the document requires of this block and its host
// R1: enable strobe low registers bus and controls; high again completes cycle.
// R2: writing bit 4 of pin-drive register as one gives host direct cam control.
// R3: in direct access, bits 3..0 drive enable, write, command, match-flag, active low.
// R4: value 0fh means no direct access, strobes high, device in charge; here the strobes follow the engine_* inputs instead.
// R5: command write uses 19h with enable high, 11h with enable low.
// R6: command read uses 1dh with enable high, 15h with enable low.
// R7: data write uses 1bh with enable high, 13h with enable low.
// R8: four cycle types: data write, data read, command write, command read.
// R9: data-word register contents drive the 16-bit cam data bus during a cycle.
// R10: host loads data word, then writes setup, enable low, enable high again.
// R11: initialization runs one command read without loading the data word.
// R12: host uses direct access only during configuration, then clears bit 4.
// R13: outside direct access the device itself drives all cam bus and strobes.
// R14: each cascaded cam gets chain position number 0 to 3.
// R15: foreground setting: 48 compare, 16 associated, no mask, enhanced, increment.
// R16: background setting: 64 compare, mask one, enhanced, increment.
// R17: foreground mask one: 8000h segment 0, zero elsewhere.
// R18: background mask one: 7f00h segment 0, ffffh in segments 1 to 3.
// R19: foreground writes segments 3:0 reads 0; background the reverse.
// R20: comparand is write destination; sources highest match and address register.
// R21: before leaving, write 1fh twice then 0fh twice.
// R22: strobes and data bus hold last written values until next host write.
`timescale 1ns/1ns
module cdap_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15:0] engine_dq_out,
    input wire logic engine_dq_oe_n,
    input wire logic engine_enable_n,
    input wire logic engine_write_n,
    input wire logic engine_command_select_n,
    input wire logic engine_match_flag_enable_n,
    input wire logic [15:0] cam_dq_in,
    output logic [15:0] cam_dq_out,
    output logic cam_dq_oe_n,
    output logic cam_enable_n,
    output logic cam_write_n,
    output logic cam_command_select_n,
    output logic cam_match_flag_enable_n,
    output logic direct_access
);
    logic [15:0] cam_pin_drive_control, next_cam_pin_drive_control;
    logic [15:0] cam_data_word_zero, next_cam_data_word_zero;
    logic [15:0] read_capture, next_read_capture;
    logic aw_held, next_aw_held, w_held, next_w_held;
    logic [3:0] aw_addr, next_aw_addr;
    logic [15:0] w_data, next_w_data;
    logic [1:0] w_lanes, next_w_lanes;
    logic awready, next_awready, wready, next_wready;
    logic bvalid, next_bvalid, arready, next_arready, rvalid, next_rvalid;
    logic [1:0] bresp, next_bresp, rresp, next_rresp;
    logic [31:0] rdata, next_rdata;
    logic [15:0] next_dq_out;
    logic next_dq_oe_n, next_en_n, next_wr_n, next_cmd_n, next_mfe_n, next_access;
    logic do_write, host_access;

    // write channel: address and data taken in either order, response after both
    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_lanes = w_lanes;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_cam_pin_drive_control = cam_pin_drive_control; // R22
        next_cam_data_word_zero = cam_data_word_zero;
        do_write = 1'b0;
        if (s_axi_awvalid && awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata[15:0];
            next_w_lanes = s_axi_wstrb[1:0];
        end
        if (next_aw_held && next_w_held && !bvalid) begin
            do_write = 1'b1;
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = cdap_pkg::resp_okay;
            // each pin-drive write changes all strobes at once; nothing in between
            case (next_aw_addr)
                cdap_pkg::addr_pin_drive: begin
                    if (next_w_lanes[0]) next_cam_pin_drive_control[7:0] = next_w_data[7:0]; // R2
                    if (next_w_lanes[1]) next_cam_pin_drive_control[15:8] = next_w_data[15:8];
                end
                cdap_pkg::addr_data_word: begin
                    if (next_w_lanes[0]) next_cam_data_word_zero[7:0] = next_w_data[7:0]; // R9
                    if (next_w_lanes[1]) next_cam_data_word_zero[15:8] = next_w_data[15:8];
                end
                cdap_pkg::addr_status: ;
                default: next_bresp = cdap_pkg::resp_slverr;
            endcase
        end else if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        next_awready = !next_aw_held && !next_bvalid;
        next_wready = !next_w_held && !next_bvalid;
    end

    // read channel: one read at a time, answer one cycle after the address
    always_comb begin
        next_arready = arready;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (s_axi_arvalid && arready) begin
            next_arready = 1'b0;
            next_rvalid = 1'b1;
            next_rresp = cdap_pkg::resp_okay;
            case (s_axi_araddr)
                cdap_pkg::addr_pin_drive: next_rdata = {16'h0000, cam_pin_drive_control};
                cdap_pkg::addr_data_word: next_rdata = {16'h0000, cam_data_word_zero};
                cdap_pkg::addr_status: next_rdata = {16'h0000, read_capture};
                default: begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = cdap_pkg::resp_slverr;
                end
            endcase
        end else if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
            next_arready = 1'b1;
        end
    end

    // cam pin mux; registered so in direct access pins change only after a completed host write
    always_comb begin
        host_access = next_cam_pin_drive_control[cdap_pkg::bit_access]; // R2
        next_access = host_access;
        next_read_capture = read_capture;
        if (host_access) begin
            next_en_n = next_cam_pin_drive_control[cdap_pkg::bit_enable]; // R1 R3
            next_wr_n = next_cam_pin_drive_control[cdap_pkg::bit_write]; // R3 R8
            next_cmd_n = next_cam_pin_drive_control[cdap_pkg::bit_cmd]; // R3
            next_mfe_n = next_cam_pin_drive_control[cdap_pkg::bit_match]; // R3
            next_dq_out = next_cam_data_word_zero; // R9
            // drive the bus only on write cycles; read cycles let the cam drive
            next_dq_oe_n = next_wr_n; // R8
            // latch read data on the rising enable that ends a read cycle
            if (cam_enable_n == 1'b0 && cam_write_n && next_en_n) begin
                next_read_capture = cam_dq_in; // R8
            end
        end else begin
            // R4: with bit 4 clear the strobes follow the engine inputs; engine owns the pins
            next_en_n = engine_enable_n; // R13
            next_wr_n = engine_write_n; // R13
            next_cmd_n = engine_command_select_n;
            next_mfe_n = engine_match_flag_enable_n;
            next_dq_out = engine_dq_out; // R13
            next_dq_oe_n = engine_dq_oe_n;
        end
    end

    // all state registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 16'h0000;
            w_lanes <= 2'h0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= 2'h0;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= 2'h0;
            cam_pin_drive_control <= cdap_pkg::pin_drive_reset; // R4
            cam_data_word_zero <= 16'h0000;
            read_capture <= 16'h0000;
            cam_dq_out <= 16'h0000;
            cam_dq_oe_n <= 1'b1;
            {cam_enable_n, cam_write_n, cam_command_select_n,
             cam_match_flag_enable_n} <= cdap_pkg::strobes_idle;
            direct_access <= 1'b0;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_lanes <= next_w_lanes;
            awready <= next_awready;
            wready <= next_wready;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            arready <= next_arready | (!arready && !rvalid && !next_rvalid);
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
            cam_pin_drive_control <= next_cam_pin_drive_control;
            cam_data_word_zero <= next_cam_data_word_zero;
            read_capture <= next_read_capture;
            cam_dq_out <= next_dq_out;
            cam_dq_oe_n <= next_dq_oe_n;
            cam_enable_n <= next_en_n;
            cam_write_n <= next_wr_n;
            cam_command_select_n <= next_cmd_n;
            cam_match_flag_enable_n <= next_mfe_n;
            direct_access <= next_access;
        end
    end

    assign s_axi_awready = awready;
    assign s_axi_wready = wready;
    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bresp;
    assign s_axi_arready = arready;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rdata = rdata;
    assign s_axi_rresp = rresp;
endmodule
